// ==== hdl/bragen_top.v ====
// Bit-reversed X-space write address generator with APB registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps

// Interface summary
// Register bus: one wait state. The access is taken at the edge where
// psel and penable stand high with pready low; pready, pslverr and
// prdata then stand for exactly one cycle, and prdata is zero otherwise.
// Byte offsets 0x000 reversal control, 0x004 address mode control,
// 0x008 read-only count of reversed writes. Other offsets answer with
// pslverr; their writes are dropped and their reads give zero.
//
// Reversal control: bit 15 is the reversal enable, bits 14:0 the pivot
// in words. Address mode control: bits 11:8 select the reversed pointer,
// bit 15 lets modulo correction run. After reset the select field holds
// the stack pointer number, so reversal stays off until software picks
// a pointer register.
//
// Address port: the core raises ea_req for one cycle with the access
// described on the other ea_ inputs. Exactly one cycle later ea_valid
// pulses with the effective address, the pointer write-back value and
// its strobe, the reversed flag and the modulo permission. A request
// may come every cycle; nothing is refused and nothing is queued.
//
// Limitations: one pointer register at a time can run reversed, and
// buffer placement is left to software. The status count is a debug
// aid and wraps without warning.
`include "bragen_defs.vh"
module bragen_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ea_req,
  input wire ea_write,
  input wire ea_byte,
  input wire [3:0] ea_wreg,
  input wire [2:0] ea_mode,
  input wire [15:0] ea_ptr,
  input wire [15:0] ea_offset,
  output reg ea_valid,
  output reg [15:0] ea_addr,
  output reg [15:0] ea_ptr_new,
  output reg ea_ptr_we,
  output reg ea_reversed,
  output reg ea_modulo_ok
);

  // Software-visible control state
  reg [15:0] reversal_control;
  reg [15:0] address_mode_control;
  // Count of reversed writes, wraps silently at 16 bits
  reg [15:0] rev_count;
  // Next values of the address answer
  reg [15:0] next_addr;
  reg [15:0] next_ptr;
  reg next_we;
  reg next_rev;
  reg next_mod;
  // Next values of the bus answer
  reg [31:0] next_prdata;
  reg next_pready;
  reg next_pslverr;
  // Fields taken from the control registers
  wire [3:0] write_pointer_select;
  wire reversal_enable;
  wire [15:0] pivot_bytes;
  // Request qualifiers
  wire incr_mode;
  wire rev_ok;
  // Bus decode
  wire apb_access;
  wire apb_write;
  wire apb_read;
  wire hit_ctrl;
  wire hit_mode;
  wire hit_stat;
  wire hit_any;

  // Add with carry travelling from bit 15 down to bit 0; the carry out
  // of bit 0 is dropped, so the sum stays inside the buffer window
  function [15:0] rev_add;
    input [15:0] a;
    input [15:0] b;
    integer i;
    reg c;
    reg [15:0] s;
    begin
      c = 1'h0;
      s = 16'h0000;
      for (i = 15; i >= 0; i = i - 1) begin
        s[i] = a[i] ^ b[i] ^ c;
        c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
      end
      rev_add = s;
    end
  endfunction

  // Pointer plus the signed mode offset, wrapping at 16 bits
  function [15:0] add_offset;
    input [15:0] ptr;
    input [15:0] ofs;
    begin
      add_offset = ptr + ofs;
    end
  endfunction

  // Clear the byte bit; reversed accesses are always word aligned
  function [15:0] word_align;
    input [15:0] a;
    begin
      word_align = a & 16'hfffe;
    end
  endfunction

  // True for the two modes that may run bit reversed
  function incr_only;
    input [2:0] mode;
    begin
      incr_only = (mode == `BRAGEN_AM_PREINC) ||
        (mode == `BRAGEN_AM_POSTINC);
    end
  endfunction

  // Whole-address match; the bus offset is compared on all 12 bits
  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // Register readback; the upper half of the bus word reads zero
  function [31:0] read_word;
    input sel_ctrl;
    input sel_mode;
    input sel_stat;
    input [15:0] ctrl;
    input [15:0] mode;
    input [15:0] stat;
    begin
      read_word = 32'h00000000;
      if (sel_ctrl)
        read_word = {16'h0000, ctrl};
      else if (sel_mode)
        read_word = {16'h0000, mode};
      else if (sel_stat)
        read_word = {16'h0000, stat};
    end
  endfunction

  // Field extraction from the mode and reversal registers
  assign write_pointer_select =
    address_mode_control[`BRAGEN_WSEL_LSB+3:`BRAGEN_WSEL_LSB];
  assign reversal_enable = reversal_control[`BRAGEN_REV_EN_BIT];
  assign pivot_bytes = {reversal_control[14:0], 1'h0};
  // Decrement modes never reverse, even with the enable set
  assign incr_mode = incr_only(ea_mode);
  // byte writes excluded
  // Only the pointer named by the select field is reversed; every other
  // W register keeps normal addressing while the mode is on
  assign rev_ok = reversal_enable && ea_write && !ea_byte &&
    (write_pointer_select != `BRAGEN_STACK_PTR) &&
    (ea_wreg == write_pointer_select) && incr_mode;

  // Normal or reversed address selection
  always @* begin
    next_rev = 1'h0;
    next_we = 1'h0;
    next_addr = ea_ptr;
    next_ptr = ea_ptr;
    next_mod = address_mode_control[`BRAGEN_MOD_X_EN_BIT];
    if (rev_ok) begin
      next_rev = 1'h1;
      next_we = 1'h1;
      next_ptr = word_align(rev_add(ea_ptr, pivot_bytes));
      if (ea_mode == `BRAGEN_AM_PREINC)
        next_addr = next_ptr;
      else
        next_addr = word_align(ea_ptr);
      next_mod = 1'h0;
    end else begin
      case (ea_mode)
        `BRAGEN_AM_POSTINC, `BRAGEN_AM_POSTDEC: begin
          next_ptr = add_offset(ea_ptr, ea_offset);
          next_we = 1'h1;
        end
        `BRAGEN_AM_PREINC, `BRAGEN_AM_PREDEC: begin
          next_ptr = add_offset(ea_ptr, ea_offset);
          next_addr = next_ptr;
          next_we = 1'h1;
        end
        // Offset mode leaves the pointer register untouched
        `BRAGEN_AM_OFFSET: begin
          next_addr = add_offset(ea_ptr, ea_offset);
        end
        default: begin
          next_addr = ea_ptr;
        end
      endcase
    end
  end

  // Registered address answer, one cycle after the request; address and
  // pointer follow every cycle, only the strobes are gated by the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_valid <= 1'h0;
      ea_addr <= 16'h0000;
      ea_ptr_new <= 16'h0000;
      ea_ptr_we <= 1'h0;
      ea_reversed <= 1'h0;
      ea_modulo_ok <= 1'h0;
    end else begin
      ea_valid <= ea_req;
      ea_addr <= next_addr;
      ea_ptr_new <= next_ptr;
      ea_ptr_we <= ea_req & next_we;
      ea_reversed <= ea_req & next_rev;
      ea_modulo_ok <= ea_req & next_mod;
    end
  end

  // Reversed-write counter for the status word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_count <= 16'h0000;
    end else if (ea_req && next_rev) begin
      rev_count <= rev_count + 16'h0001;
    end
  end

  // Bus decode; an access is taken once, in the cycle before pready
  assign apb_access = psel && penable && !pready;
  assign apb_write = apb_access && pwrite;
  assign apb_read = apb_access && !pwrite;
  assign hit_ctrl = addr_hit(paddr, `BRAGEN_OFF_REV_CTRL);
  assign hit_mode = addr_hit(paddr, `BRAGEN_OFF_MODE_CTRL);
  assign hit_stat = addr_hit(paddr, `BRAGEN_OFF_STATUS);
  assign hit_any = hit_ctrl || hit_mode || hit_stat;

  // Bus answer for the next cycle; read data stays zero outside pready
  always @* begin
    next_pready = apb_access;
    next_pslverr = apb_access && !hit_any;
    next_prdata = 32'h00000000;
    if (apb_read) begin
      next_prdata = read_word(hit_ctrl, hit_mode, hit_stat,
        reversal_control, address_mode_control, rev_count);
    end
  end

  // Bus answer registers: one wait state, pready a one-cycle pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Control registers. A write lands at the edge that takes the access,
  // the same edge that raises pready, so an address request in the pready
  // cycle already sees the new mode; the status word ignores writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reversal_control <= `BRAGEN_REV_CTRL_RESET;
      address_mode_control <= `BRAGEN_MODE_CTRL_RESET;
    end else begin
      if (apb_write && hit_ctrl)
        reversal_control <= pwdata[15:0];
      if (apb_write && hit_mode)
        address_mode_control <= pwdata[15:0];
    end
  end

endmodule

// ==== hdl/bragen_defs.vh ====
// Constants for the bit-reversed write address generator
`ifndef BRAGEN_DEFS_VH
`define BRAGEN_DEFS_VH
`define BRAGEN_OFF_REV_CTRL 12'h000
`define BRAGEN_OFF_MODE_CTRL 12'h004
`define BRAGEN_OFF_STATUS 12'h008
`define BRAGEN_REV_EN_BIT 15
`define BRAGEN_REV_CTRL_RESET 16'h0000
`define BRAGEN_MODE_CTRL_RESET 16'h0f00
`define BRAGEN_WSEL_LSB 8
`define BRAGEN_MOD_X_EN_BIT 15
`define BRAGEN_STACK_PTR 4'hf
`define BRAGEN_AM_INDIRECT 3'h0
`define BRAGEN_AM_POSTDEC 3'h1
`define BRAGEN_AM_POSTINC 3'h2
`define BRAGEN_AM_PREDEC 3'h3
`define BRAGEN_AM_PREINC 3'h4
`define BRAGEN_AM_OFFSET 3'h5
`endif

// ==== bench/bragen_asserts.sv ====
// Port assertions for the bit-reversed write address generator
`timescale 1ns/1ps
module bragen_asserts (
  input wire pclk,
  input wire presetn,
  input wire ea_req,
  input wire ea_write,
  input wire ea_byte,
  input wire ea_valid,
  input wire ea_ptr_we,
  input wire ea_reversed,
  input wire ea_modulo_ok,
  input wire [3:0] ea_wreg,
  input wire [2:0] ea_mode,
  input wire [15:0] ea_addr,
  input wire [15:0] ea_ptr_new
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; ea_req |=> ea_valid; endproperty
  property p_idle; !ea_req |=> !ea_valid; endproperty
  property p_wr; ea_reversed |-> $past(ea_write) && ea_valid; endproperty
  property p_sel; ea_reversed |-> $past(ea_wreg) != 4'hf; endproperty
  // Word writes in pre or post increment only
  property p_mode; ea_reversed |-> !$past(ea_byte) &&
    ($past(ea_mode) == 3'h2 || $past(ea_mode) == 3'h4); endproperty
  property p_lsb; ea_reversed |-> !ea_addr[0] && !ea_ptr_new[0]; endproperty
  property p_wb; ea_reversed |-> ea_ptr_we; endproperty
  property p_mod; ea_reversed |-> !ea_modulo_ok; endproperty
  // Pre-increment hands out the freshly formed pointer as the address
  property p_pre; ea_reversed && $past(ea_mode) == 3'h4 |->
    ea_addr == ea_ptr_new; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_idle: assert property (p_idle) else $error("stray valid");
  a_wr: assert property (p_wr) else $error("reversed read");
  a_sel: assert property (p_sel) else $error("stack reversed");
  a_mode: assert property (p_mode) else $error("bad mode");
  a_lsb: assert property (p_lsb) else $error("odd address");
  a_wb: assert property (p_wb) else $error("no writeback");
  a_mod: assert property (p_mod) else $error("modulo kept");
  a_pre: assert property (p_pre) else $error("preinc address");
  c_rev: cover property (ea_reversed);
  c_back: cover property (ea_reversed ##2 ea_reversed);
  c_norm: cover property (ea_valid && !ea_reversed);
endmodule
bind bragen_top bragen_asserts u_chk (.*);

// ==== bench/bragen_core.sv ====
// Core-side model issuing indirect data accesses
`timescale 1ns/1ps
module bragen_core (
  input wire pclk,
  output reg ea_req = 0,
  output reg ea_write = 0,
  output reg ea_byte = 0,
  output reg [3:0] ea_wreg = 0,
  output reg [2:0] ea_mode = 0,
  output reg [15:0] ea_ptr = 0,
  output reg [15:0] ea_offset = 0
);
  // One pulse; operands scrambled once taken so stale reuse shows
  task issue(input w, b, input [3:0] r, input [2:0] m, input [15:0] p, o);
    begin
      ea_req <= 1;
      {ea_write, ea_byte, ea_wreg, ea_mode} <= {w, b, r, m};
      {ea_ptr, ea_offset} <= {p, o};
      @(posedge pclk);
      ea_req <= 0;
      {ea_ptr, ea_offset} <= ~{p, o};
      @(posedge pclk);
    end
  endtask
endmodule

// ==== bench/testbench.sv ====
// Register and address checks of the address generator
`timescale 1ns/1ps
module testbench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, ea_req, ea_write, ea_byte, ea_valid, ea_ptr_we;
  wire ea_reversed, ea_modulo_ok;
  wire [3:0] ea_wreg;
  wire [2:0] ea_mode;
  wire [15:0] ea_ptr, ea_offset, ea_addr, ea_ptr_new;
  integer err_count = 0, tests_run = 0, cyc = 0;
  bragen_top dut (.*);
  bragen_core core (.*);
  always #20 pclk = ~pclk;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Hang guard, far above the fewer than a hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  task chk(input [47:0] n, input [31:0] s, e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("MISMATCH %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  // Setup then access; held until pready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge pclk);
    end
  endtask
  task ea(input w, b, input [3:0] r, input [2:0] m,
    input [15:0] p, o, a, n, input v);
    begin
      core.issue(w, b, r, m, p, o);
      chk("valid", ea_valid, 1);
      chk("addr", ea_addr, a);
      chk("ptr", ea_ptr_new, n);
      chk("we", ea_ptr_we, m != 3'h0 && m != 3'h5);
      chk("rev", ea_reversed, v);
      chk("mod", ea_modulo_ok, !v);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    chk("ctl", rd, 0);
    apb(0, 12'h004, 0);
    chk("mode", rd, 32'h0f00);
    apb(0, 12'h00c, 0);
    chk("slverr", er, 1);
    $display("register test done");
    apb(1, 12'h004, 32'h8300); // modulo on, pointer 3 selected
    apb(1, 12'h000, 32'h8008); // reversal on, pivot of 8 words
    // buffer of 32 bytes starts on a 32-byte boundary
    ea(1, 0, 3, 2, 16'h1000, 2, 16'h1000, 16'h1010, 1);
    ea(1, 0, 3, 4, 16'h1010, 2, 16'h1008, 16'h1008, 1);
    ea(1, 0, 3, 2, 16'h1001, 2, 16'h1000, 16'h1010, 1);
    $display("reversed test done");
    ea(0, 0, 3, 2, 16'h1000, 2, 16'h1000, 16'h1002, 0);
    ea(1, 1, 3, 4, 16'h1000, 2, 16'h1002, 16'h1002, 0);
    ea(1, 0, 3, 3, 16'h1000, 16'hfffe, 16'h0ffe, 16'h0ffe, 0);
    ea(1, 0, 4, 2, 16'h1000, 2, 16'h1000, 16'h1002, 0);
    ea(1, 0, 3, 0, 16'h1000, 2, 16'h1000, 16'h1000, 0);
    ea(1, 0, 3, 5, 16'h1000, 4, 16'h1004, 16'h1000, 0);
    ea(0, 0, 3, 1, 16'h1000, 16'hfffe, 16'h1000, 16'h0ffe, 0);
    apb(1, 12'h004, 32'h8f00);
    ea(1, 0, 15, 2, 16'h1000, 2, 16'h1000, 16'h1002, 0);
    apb(0, 12'h008, 0);
    chk("count", rd, 3);
    $display("fallback test done");
    conclude;
  end
endmodule
